// File: cddp_pkg.sv
// Constants, field layouts and types for the channel divider duty and phase block
// Functional notes
// - Duty correction is on after reset; each channel can disable it alone.
// - Correction with matching counts forces the divider output to 50% duty.
// - Uncorrected divider output is high for (N+1) of (N+M+2) input cycles.
// - Bypassed channel after odd VCO divider 3/5 gives 33.3%/40%, or 50% corrected from a 50% input.
// - With X% input, corrected VCO divider 3/5 gives (1+X)/3 or (2+X)/5.
// - Odd VCO 3/5 with odd corrected channel gives (3N+4+X)/(6N+9), (5N+7+X)/(10N+15).
// - VCO divider 1, odd corrected channel, X% input gives (N+1+X)/(2N+3).
// - VCO divider and channel both bypassed: output follows input duty exactly.
// - Direct-to-output routing passes the selected source clock unchanged.
// - Phase setting delays the output rising edge by whole input rising edges.
// - Phase code is start_high times 16 plus the four phase_offset bits.
// - Code up to 15 delays code cycles; 16 and up delays code-16+M+1.
// - A new phase setting takes effect only after an alignment operation.
// - Phase byte: start_high bit 4, offset 3:0; count byte: low 7:4, high 3:0.
// - Each channel keeps its own phase offset, independent of the others.
// - Divider gives M+1 low and N+1 high input cycles; bypass divides by one.
// - Correction disable is bit 0 of the per-channel control byte.
package cddp_pkg;
    localparam int NUM_CH = 4;
    localparam int IDX_W = 10;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_DIV0_CYCLE_COUNTS = 10'h190;
    localparam logic [9:0] IDX_DIV0_PHASE_SETTING = 10'h191;
    localparam logic [9:0] IDX_DIV0_CONTROL = 10'h192;
    localparam logic [9:0] IDX_DIV1_CYCLE_COUNTS = 10'h193;
    localparam logic [9:0] IDX_DIV1_PHASE_SETTING = 10'h194;
    localparam logic [9:0] IDX_DIV1_CONTROL = 10'h195;
    localparam logic [9:0] IDX_DIV2_CYCLE_COUNTS = 10'h196;
    localparam logic [9:0] IDX_DIV2_PHASE_SETTING = 10'h197;
    localparam logic [9:0] IDX_DIV2_CONTROL = 10'h198;
    localparam logic [9:0] IDX_DIV3_CYCLE_COUNTS = 10'h199;
    localparam logic [9:0] IDX_DIV3_PHASE_SETTING = 10'h19A;
    localparam logic [9:0] IDX_DIV3_CONTROL = 10'h19B;
    localparam logic [9:0] IDX_CH_STRIDE = 10'h003;
    localparam logic [9:0] IDX_DIST_CFG = 10'h1E0;
    localparam logic [9:0] IDX_SYNC_CTRL = 10'h230;
    localparam logic [9:0] IDX_STATUS = 10'h231;
    // Field positions
    localparam int CNT_LOW_MSB = 7;
    localparam int CNT_LOW_LSB = 4;
    localparam int CNT_HIGH_MSB = 3;
    localparam int CNT_HIGH_LSB = 0;
    localparam int PH_BYPASS_BIT = 7;
    localparam int PH_START_HIGH_BIT = 4;
    localparam int PH_OFFSET_MSB = 3;
    localparam int PH_OFFSET_LSB = 0;
    localparam int CTL_DCC_DIS_BIT = 0;
    localparam int CTL_DIRECT_BIT = 1;
    localparam int DIST_VDIV_MSB = 2;
    localparam int DIST_VDIV_LSB = 0;
    localparam int DIST_VBYP_BIT = 3;
    localparam int SYNC_SOFT_BIT = 0;
    // Reset values
    localparam logic [7:0] RST_COUNTS = 8'h00;
    localparam logic [7:0] RST_PHASE = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_DIST = 8'h02;
    localparam logic [7:0] RST_SYNC = 8'h00;
    localparam logic [1:0] CTL_MASK = 2'h3;
    localparam logic [2:0] VDIV_MIN = 3'h1;
    localparam logic [2:0] VDIV_MAX = 3'h6;
    localparam logic [4:0] PHI_CASE2_MIN = 5'h10;

    typedef struct packed {
        logic bypass;
        logic start_high;
        logic [3:0] phase_offset;
        logic [3:0] low_cnt;
        logic [3:0] high_cnt;
        logic dcc_dis;
        logic direct;
    } cddp_cfg_s;

    typedef enum logic [1:0] {
        ST_SYNC = 2'b00,
        ST_WAIT = 2'b01,
        ST_HIGH = 2'b10,
        ST_LOW = 2'b11
    } cddp_st_e;
endpackage

// File: cddp_top.sv
// Channel dividers with duty correction, coarse phase delay and APB registers
`timescale 1ns/1ps

module cddp_chan
    import cddp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_sync_b,
    input wire cddp_cfg_s cfg,
    input wire logic sync_hold,
    input wire logic src_lvl,
    input wire logic vco_raw,
    input wire logic vco_ext,
    input wire logic vco_bypass,
    output logic clk_out,
    output logic running
);
    cddp_st_e st_q;
    cddp_st_e st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [4:0] dly_q;
    logic [4:0] dly_d;
    logic [4:0] ph_q;
    logic ci_q;
    logic out_q;
    logic out_d;

    wire logic dcc_on = ~cfg.dcc_dis;
    // Correction also stretches the high time of the VCO stage feeding this channel
    wire logic ci = vco_bypass ? src_lvl : (dcc_on ? vco_ext : vco_raw);
    wire logic ci_rise = ci & ~ci_q;
    // Odd split only corrected when low is one above high
    wire logic odd_ok = dcc_on & ({1'b0, cfg.low_cnt} == ({1'b0, cfg.high_cnt} + 5'h01));
    wire logic [4:0] phi = {cfg.start_high, cfg.phase_offset};
    wire logic [4:0] delay_c2 = ph_q - PHI_CASE2_MIN + {1'b0, cfg.low_cnt} + 5'h01;
    wire logic [4:0] delay = (ph_q >= PHI_CASE2_MIN) ? delay_c2 : ph_q;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        dly_d = dly_q;
        case (st_q)
            ST_SYNC: begin
                st_d = ST_WAIT;
                dly_d = delay;
            end
            ST_WAIT: begin
                if (ci_rise) begin
                    if (dly_q == 5'h00) begin
                        st_d = ST_HIGH;
                        cnt_d = 4'h0;
                    end else begin
                        dly_d = dly_q - 5'h01;
                    end
                end
            end
            ST_HIGH: begin
                if (ci_rise) begin
                    if (cnt_q == cfg.high_cnt) begin
                        st_d = ST_LOW;
                        cnt_d = 4'h0;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
            end
            ST_LOW: begin
                if (ci_rise) begin
                    if (cnt_q == cfg.low_cnt) begin
                        st_d = ST_HIGH;
                        cnt_d = 4'h0;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
            end
            default: begin
                st_d = ST_SYNC;
            end
        endcase
        if (sync_hold) begin
            st_d = ST_SYNC;
            cnt_d = 4'h0;
        end
    end

    // Odd correction stretches high into the first low cycle until the input falls
    wire logic stretch = odd_ok & (st_d == ST_LOW) & (cnt_d == 4'h0) & ci;
    wire logic div_lvl = (st_d == ST_HIGH) | stretch;

    always_comb begin
        if (cfg.direct) begin
            out_d = src_lvl;
        end else if (st_d == ST_SYNC) begin
            out_d = cfg.start_high;
        end else if (cfg.bypass) begin
            out_d = ci;
        end else if (st_d == ST_WAIT) begin
            out_d = 1'b0;
        end else begin
            out_d = div_lvl;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_q <= ST_WAIT;
            cnt_q <= 4'h0;
            dly_q <= 5'h00;
            ph_q <= 5'h00;
            ci_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            dly_q <= dly_d;
            ci_q <= ci;
            out_q <= out_d;
            // Phase is shadowed only while alignment is held
            if (sync_hold) begin
                ph_q <= phi;
            end
        end
    end

    assign clk_out = out_q;
    assign running = (st_q == ST_HIGH) | (st_q == ST_LOW);
endmodule

////////////////////////////////////////////////////////////////////////////////

module cddp_top
    import cddp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic src_clk,
    output logic [NUM_CH-1:0] ch_clk_out
);
    logic [1:0] rst_ff_q;
    logic [2:0] src_ff_q;
    logic src_lvl_q;
    logic src_prev_q;
    logic [2:0] vcnt_q;
    logic [7:0] cnt_reg_q [NUM_CH];
    logic [7:0] ph_reg_q [NUM_CH];
    logic [1:0] ctl_reg_q [NUM_CH];
    logic [7:0] dist_q;
    logic [7:0] sync_q;
    logic [31:0] prdata_q;
    logic err_q;
    logic [NUM_CH-1:0] run;
    logic [NUM_CH-1:0] hit_cnt;
    logic [NUM_CH-1:0] hit_ph;
    logic [NUM_CH-1:0] hit_ctl;
    logic [7:0] rd_ch;

    wire logic rst_sync_b = rst_ff_q[1];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_ff_q <= 2'h0;
        end else begin
            rst_ff_q <= {rst_ff_q[0], 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source clock sampling; a level counts once the last two stages agree

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            src_ff_q <= 3'h0;
            src_lvl_q <= 1'b0;
            src_prev_q <= 1'b0;
        end else begin
            src_ff_q <= {src_ff_q[1:0], src_clk};
            src_prev_q <= src_lvl_q;
            if (src_ff_q[1] == src_ff_q[2]) begin
                src_lvl_q <= src_ff_q[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // VCO divider stage, shared by all channels

    wire logic sync_hold = sync_q[SYNC_SOFT_BIT];
    wire logic vco_bypass = dist_q[DIST_VBYP_BIT];
    wire logic [2:0] vdiv_raw = dist_q[DIST_VDIV_MSB:DIST_VDIV_LSB];
    wire logic [2:0] vdiv_lo = (vdiv_raw < VDIV_MIN) ? VDIV_MIN : vdiv_raw;
    wire logic [2:0] vdiv = (vdiv_lo > VDIV_MAX) ? VDIV_MAX : vdiv_lo;
    wire logic [2:0] vhalf = {1'b0, vdiv[2:1]};
    wire logic src_rise = src_lvl_q & ~src_prev_q;
    wire logic [2:0] vcnt_inc = (vcnt_q == (vdiv - 3'h1)) ? 3'h0 : (vcnt_q + 3'h1);
    wire logic [2:0] vcnt_nx = sync_hold ? 3'h0 : (src_rise ? vcnt_inc : vcnt_q);
    wire logic vdiv_one = (vdiv == VDIV_MIN);
    // Divide by one has no half count, so the source passes through
    wire logic vco_raw = vdiv_one ? src_lvl_q : (vcnt_nx < vhalf);
    // Odd ratio stretch keeps the input's high time into the middle cycle
    wire logic vco_ext = vco_raw | (vdiv[0] & ~vdiv_one & (vcnt_nx == vhalf) & src_lvl_q);

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            vcnt_q <= 3'h0;
        end else begin
            vcnt_q <= vcnt_nx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB decode; pready is constant so every access completes in one cycle

    wire logic [9:0] idx = paddr[11:2];
    wire logic aligned = (paddr[1:0] == 2'h0) & (paddr[31:12] == 20'h00000);
    wire logic hit_dist = idx == IDX_DIST_CFG;
    wire logic hit_sync = idx == IDX_SYNC_CTRL;
    wire logic hit_stat = idx == IDX_STATUS;
    wire logic mapped = aligned & ((|hit_cnt) | (|hit_ph) | (|hit_ctl) | hit_dist | hit_sync
                                   | hit_stat);
    wire logic wr_en = psel & penable & pwrite & pstrb[0] & mapped;
    wire logic setup = psel & ~penable;

    genvar k;
    generate
        for (k = 0; k < NUM_CH; k++) begin : g_ch
            localparam logic [9:0] OFS = IDX_CH_STRIDE * 10'(k);
            cddp_cfg_s cfg;
            assign hit_cnt[k] = idx == (IDX_DIV0_CYCLE_COUNTS + OFS);
            assign hit_ph[k] = idx == (IDX_DIV0_PHASE_SETTING + OFS);
            assign hit_ctl[k] = idx == (IDX_DIV0_CONTROL + OFS);

            always_ff @(posedge clk or negedge rst_sync_b) begin
                if (!rst_sync_b) begin
                    cnt_reg_q[k] <= RST_COUNTS;
                    ph_reg_q[k] <= RST_PHASE;
                    ctl_reg_q[k] <= RST_CTRL[1:0];
                end else begin
                    if (wr_en & hit_cnt[k]) begin
                        cnt_reg_q[k] <= pwdata[7:0];
                    end
                    if (wr_en & hit_ph[k]) begin
                        ph_reg_q[k] <= pwdata[7:0];
                    end
                    if (wr_en & hit_ctl[k]) begin
                        ctl_reg_q[k] <= pwdata[1:0] & CTL_MASK;
                    end
                end
            end

            assign cfg.low_cnt = cnt_reg_q[k][CNT_LOW_MSB:CNT_LOW_LSB];
            assign cfg.high_cnt = cnt_reg_q[k][CNT_HIGH_MSB:CNT_HIGH_LSB];
            assign cfg.bypass = ph_reg_q[k][PH_BYPASS_BIT];
            assign cfg.start_high = ph_reg_q[k][PH_START_HIGH_BIT];
            assign cfg.phase_offset = ph_reg_q[k][PH_OFFSET_MSB:PH_OFFSET_LSB];
            assign cfg.dcc_dis = ctl_reg_q[k][CTL_DCC_DIS_BIT];
            assign cfg.direct = ctl_reg_q[k][CTL_DIRECT_BIT];

            cddp_chan u_chan (
                .clk(clk),
                .rst_sync_b(rst_sync_b),
                .cfg(cfg),
                .sync_hold(sync_hold),
                .src_lvl(src_lvl_q),
                .vco_raw(vco_raw),
                .vco_ext(vco_ext),
                .vco_bypass(vco_bypass),
                .clk_out(ch_clk_out[k]),
                .running(run[k])
            );
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            dist_q <= RST_DIST;
            sync_q <= RST_SYNC;
        end else begin
            if (wr_en & hit_dist) begin
                dist_q <= {4'h0, pwdata[3:0]};
            end
            if (wr_en & hit_sync) begin
                sync_q <= {7'h00, pwdata[SYNC_SOFT_BIT]};
            end
        end
    end

    always_comb begin
        rd_ch = 8'h00;
        for (int i = 0; i < NUM_CH; i++) begin
            if (hit_cnt[i]) begin
                rd_ch = rd_ch | cnt_reg_q[i];
            end
            if (hit_ph[i]) begin
                rd_ch = rd_ch | ph_reg_q[i];
            end
            if (hit_ctl[i]) begin
                rd_ch = rd_ch | {6'h00, ctl_reg_q[i]};
            end
        end
    end

    wire logic [7:0] status = {run, ch_clk_out};
    wire logic [7:0] rd_byte = rd_ch | (hit_dist ? dist_q : 8'h00) | (hit_sync ? sync_q : 8'h00)
                             | (hit_stat ? status : 8'h00);

    // Read data captured in setup so it is stable through the access cycle
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            prdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= (mapped & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
            err_q <= ~mapped;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & err_q;
endmodule

// File: cddp_props.sv
// Checker of bus and output-clock relations for the channel divider block
`timescale 1ns/1ps
module cddp_props
    import cddp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic src_clk,
    input wire logic [NUM_CH-1:0] ch_clk_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    logic src_q;
    logic [4:0] quiet_q;
    logic [4:0] quiet_d;
    wire setup = psel && !penable;
    wire acc = psel && penable;
    // Saturating count of cycles with neither source edges nor bus traffic
    assign quiet_d = (psel || src_clk != src_q) ? 5'h00 : quiet_q + {4'h0, quiet_q != 5'h1F};
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            src_q <= 1'b0;
            quiet_q <= 5'h00;
        end else begin
            src_q <= src_clk;
            quiet_q <= quiet_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_in_access: assert property (pslverr |-> acc) else $error("error outside access");
    a_misalign_err: assert property (
        setup && paddr[1:0] != 2'h0 ##1 acc |-> pslverr && prdata == 32'h0)
        else $error("misaligned access accepted");
    a_high_addr_err: assert property (
        setup && paddr[31:12] != 20'h0 ##1 acc |-> pslverr)
        else $error("out of range access accepted");
    a_mapped_ok: assert property (
        setup && paddr == {20'h0, IDX_DIV1_CYCLE_COUNTS, 2'b00} ##1 acc
        |-> !pslverr && prdata[31:8] == 24'h0) else $error("mapped access refused");
    a_ctrl_reserved: assert property (
        setup && !pwrite && paddr == {20'h0, IDX_DIV2_CONTROL, 2'b00}
        ##1 acc |-> prdata[7:2] == 6'h00) else $error("control upper bits set");
    a_prdata_hold: assert property (!psel |-> $stable(prdata)) else $error("read data moved idle");
    a_quiet_output: assert property (quiet_q >= 5'h10 |-> $stable(ch_clk_out))
        else $error("output moved without input edge");
    c_err_seen: cover property (acc && pslverr);
    c_write_done: cover property (acc && pwrite && !pslverr);
    c_all_high: cover property (&ch_clk_out);
endmodule
bind cddp_top cddp_props props_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_clk(src_clk), .ch_clk_out(ch_clk_out));

// File: testbench.sv
// Self-checking bench for the channel divider block
`timescale 1ns/1ps
module testbench
    import cddp_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic src_clk = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_CH-1:0] ch_clk_out;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int s_cnt = 0;
    bit src_en = 1'b0;
    int mdl[int];
    int m;
    int per;
    // Source is 5 clk high, 3 low; VCO setting 8 means VCO divider bypassed
    int tdv[12] = '{1, 8, 8, 8, 8, 3, 3, 5, 5, 2, 3, 2};
    int tcn[12] = '{8'h10, 8'h23, 8'hFF, 8'h32, 0, 0, 0, 0, 0, 0, 8'h21, 0};
    int tph[12] = '{0, 0, 0, 0, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 0, 0};
    int tct[12] = '{0, 1, 1, 0, 0, 1, 0, 1, 0, 0, 0, 2};
    int thi[12] = '{13, 32, 128, 29, 5, 8, 13, 16, 21, 8, 61, 5};
    int tlo[12] = '{11, 24, 128, 27, 3, 16, 11, 24, 19, 8, 59, 3};
    int pa[4] = '{0, 5, 15, 16};
    int pb[4] = '{0, 1, 21, 31};
    logic [31:0] ra[3] = '{32'h00000790, 32'h00000641, 32'h00010640};

    cddp_top dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_clk(src_clk), .ch_clk_out(ch_clk_out));

    initial begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (!src_en) begin
            src_clk <= 1'b0;
            s_cnt <= 0;
        end else if (s_cnt == (src_clk ? 4 : 2)) begin
            src_clk <= ~src_clk;
            s_cnt <= 0;
        end else begin
            s_cnt <= s_cnt + 1;
        end
        if (cyc == 40000) begin
            fail_count++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // Idle edge first, so back-to-back calls never drive psel twice at one edge
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] msk(input int i);
        if (i >= 'h192 && i <= 'h19B && (i - 'h192) % 3 == 0) return 8'h03;
        if (i == 'h1E0) return 8'h0F;
        if (i == 'h230) return 8'h01;
        return 8'hFF;
    endfunction

    task automatic wreg(input int i, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, 32'(i * 4), {24'h0, d}, 4'hF, r, e);
        mdl[i] = int'(d & msk(i));
    endtask

    task automatic creg(input int i);
        logic [31:0] r;
        logic e;
        apb(1'b0, 32'(i * 4), 32'h0, 4'h0, r, e);
        chk("register", 32'(mdl[i]), r);
        chk("error flag", 32'h0, {31'h0, e});
    endtask

    task automatic wait_lvl(input int c, input logic v, output int n);
        n = 0;
        while (ch_clk_out[c] !== v && n < 3000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic meas(input int c, input int ehi, input int elo);
        int h;
        int l;
        wait_lvl(c, 1'b0, h);
        wait_lvl(c, 1'b1, h);
        wait_lvl(c, 1'b0, h);
        wait_lvl(c, 1'b1, h);
        wait_lvl(c, 1'b0, h);
        wait_lvl(c, 1'b1, l);
        chk("high time", 32'(ehi), 32'(h));
        chk("low time", 32'(elo), 32'(l));
    endtask

    // First rise of each output, seen only after a low sample
    task automatic track(output int t[4]);
        logic [NUM_CH-1:0] pv;
        pv = '1;
        t = '{-1, -1, -1, -1};
        for (int n = 0; n < 1500; n++) begin
            @(negedge clk);
            for (int c = 0; c < 4; c++) begin
                if (t[c] < 0 && !pv[c] && ch_clk_out[c] === 1'b1)
                    t[c] = n;
            end
            pv = ch_clk_out;
        end
    endtask

    task automatic phase_run(input int cd[4], input int ex[4], input bit syn);
        int t[4];
        int d;
        int g;
        for (int c = 0; c < 4; c++) wreg(int'(IDX_DIV0_PHASE_SETTING) + 3 * c, 8'(cd[c]));
        if (syn) begin
            wreg(int'(IDX_SYNC_CTRL), 8'h01);
            repeat (8) @(negedge clk);
            for (int c = 0; c < 4; c++) begin
                chk("held level", 32'((cd[c] >> 4) & 1), 32'(ch_clk_out[c]));
            end
            wreg(int'(IDX_SYNC_CTRL), 8'h00);
        end
        track(t);
        for (int c = 0; c < 4; c++) begin
            d = (ex[c] <= 15) ? ex[c] : ex[c] - 16 + m + 1;
            g = ((t[c] - t[0]) % per + per) % per;
            chk("phase gap", 32'((d * 8) % per), 32'(g));
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic e;
        int c;
        for (int i = 'h190; i <= 'h19B; i++) mdl[i] = 0;
        mdl['h1E0] = 2;
        mdl['h230] = 0;
        void'($urandom(62));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (30) @(posedge clk);
        for (int i = 'h190; i <= 'h19B; i++) begin
            creg(i);
            wreg(i, 8'($urandom));
            creg(i);
            wreg(i, 8'h00);
        end
        creg(int'(IDX_DIST_CFG));
        creg(int'(IDX_SYNC_CTRL));
        apb(1'b1, 32'h00000640, 32'h000000AB, 4'h0, r, e);
        for (int k = 0; k < 3; k++) begin
            apb(k == 1, ra[k], 32'h000000CD, 4'hF, r, e);
            chk("refused flag", 32'h1, {31'h0, e});
            chk("refused data", 32'h0, r);
        end
        creg(int'(IDX_DIV0_CYCLE_COUNTS));
        src_en = 1'b1;
        for (int k = 0; k < 12; k++) begin
            c = k % 4;
            wreg(int'(IDX_DIST_CFG), 8'(tdv[k]));
            wreg(int'(IDX_DIV0_CYCLE_COUNTS) + 3 * c, 8'(tcn[k]));
            wreg(int'(IDX_DIV0_PHASE_SETTING) + 3 * c, 8'(tph[k]));
            wreg(int'(IDX_DIV0_CONTROL) + 3 * c, 8'(tct[k]));
            wreg(int'(IDX_SYNC_CTRL), 8'h01);
            wreg(int'(IDX_SYNC_CTRL), 8'h00);
            meas(c, thi[k], tlo[k]);
        end
        m = 8 + int'($urandom % 8);
        per = (m + 8 + int'($urandom % 8) + 2) * 8;
        wreg(int'(IDX_DIST_CFG), 8'h08);
        for (int k = 0; k < 4; k++) begin
            wreg(int'(IDX_DIV0_CYCLE_COUNTS) + 3 * k, 8'((m << 4) | (per / 8 - m - 2)));
            wreg(int'(IDX_DIV0_CONTROL) + 3 * k, 8'h01);
        end
        phase_run(pa, pa, 1'b1);
        phase_run(pb, pb, 1'b1);
        phase_run(pa, pb, 1'b0);
        src_en = 1'b0;
        repeat (40) @(posedge clk);
        report_and_stop();
    end
endmodule
